// File: src/scms_regs.vh
`ifndef SCMS_REGS_VH
`define SCMS_REGS_VH
`define SCMS_ADDR_IFCFG 8'h02
`define SCMS_ADDR_CFGA 8'h12
`define SCMS_ADDR_TH0 8'h13
`define SCMS_ADDR_TH1 8'h14
`define SCMS_ADDR_TH2 8'h15
`define SCMS_ADDR_CFGB 8'h16
`define SCMS_WRITE_OFS 8'h40
`define SCMS_WRITE_END 8'h80
`define SCMS_RES_BASE 5'h0C
`define SCMS_LAST_STEP 2'h3
`define SCMS_CMD_NOM 8'hA8
`define SCMS_CMD_CM 8'hA9
`define SCMS_CMD_MEAS 8'hAA
`define SCMS_CMD_CYC 8'hAB
`define SCMS_INT_LSB 7
`define SCMS_INT_MSB 8
`define SCMS_SSPOL_BIT 9
`define SCMS_CYC_LSB 12
`define SCMS_CYC_MSB 14
`define SCMS_RES_LSB 0
`define SCMS_RES_MSB 2
`define SCMS_INT_EOC 2'h0
`define SCMS_INT_ABOVE 2'h1
`define SCMS_INT_BELOW 2'h2
`define SCMS_MUX_ANALOG_GROUND_REF 2'h0
`define SCMS_MUX_SENSOR 2'h1
`define SCMS_MUX_TEMP 2'h2
`define SCMS_IF_NONE 2'h0
`define SCMS_IF_TWI 2'h1
`define SCMS_IF_SPI 2'h2
`define SCMS_RST_WORD 16'h0000
`endif

// File: src/scms_sequencer.v
`timescale 1ns/1ps
`include "scms_regs.vh"
module scms_sequencer #(
   parameter CLK_MHZ = 250,
   parameter STA1_US = 1,
   parameter STA2_US = 2,
   parameter WUP1_US = 1,
   parameter WUP2_US = 2,
   parameter INIT_CYC = 16,
   parameter CYC_UNIT = 8192,
   parameter STEP_CYC = 64,
   parameter CALC_CYC = 32
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_ext_reset_pin,
   input wire i_slave_select,
   input wire i_twi_cmd_valid,
   input wire i_spi_cmd_valid,
   input wire [7:0] i_cmd_byte,
   input wire [15:0] i_cmd_data,
   input wire i_corr_valid,
   input wire [23:0] i_corr_result,
   output wire o_cmd_ready,
   output reg [15:0] o_read_data,
   output reg o_read_valid,
   output reg [1:0] o_if_type,
   output reg o_core_on,
   output reg o_cfg_temp,
   output reg [1:0] o_amp_mux,
   output reg o_adc_start,
   output reg o_calc_start,
   output reg o_cmd_mode,
   output reg o_conv_done
);
   // ****************************************
   // timing
   // ****************************************
   localparam STA1_CYC = STA1_US * CLK_MHZ;
   localparam STA2_CYC = STA2_US * CLK_MHZ;
   localparam WUP1_CYC = WUP1_US * CLK_MHZ;
   localparam WUP2_CYC = WUP2_US * CLK_MHZ;

   // ****************************************
   // state codes, one hot
   // ****************************************
   localparam S_INIT = 8'h01;
   localparam S_SLEEP = 8'h02;
   localparam S_WAKE = 8'h04;
   localparam S_ACTIVE = 8'h08;
   localparam S_STEP = 8'h10;
   localparam S_CALC = 8'h20;
   localparam S_PAUSE = 8'h40;
   localparam S_UNUSED = 8'h80;

   // ****************************************
   // synchronisers and reset pin
   // ****************************************
   reg [1:0] rpin_sync;
   reg [1:0] ss_sync;
   reg rpin_prev;
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rpin_sync <= 2'h3;
         ss_sync <= 2'h0;
         rpin_prev <= 1'b1;
      end else begin
         rpin_sync <= {rpin_sync[0], i_ext_reset_pin};
         ss_sync <= {ss_sync[0], i_slave_select};
         rpin_prev <= rpin_sync[1];
      end
   end
   wire pin_fall = rpin_prev & ~rpin_sync[1];

   // ****************************************
   // registers
   // ****************************************
   // configuration words; only a power-on reset clears them
   reg [15:0] ifcfg;
   reg [15:0] cfga;
   reg [15:0] th0;
   reg [15:0] th1;
   reg [15:0] th2;
   reg [15:0] cfgb;

   // ****************************************
   // sequencer state
   // ****************************************
   reg [7:0] state;
   reg [31:0] cnt;
   // stops at the longer start-up delay so it never wraps
   reg [31:0] up_cnt;
   reg first_cmd;
   reg [1:0] step;
   reg cyclic;
   reg meas_req;

   // ****************************************
   // command decode
   // ****************************************
   wire cmd_valid = i_twi_cmd_valid | i_spi_cmd_valid;
   wire sta1_done = up_cnt >= STA1_CYC;
   wire sta2_done = up_cnt >= STA2_CYC;
   wire in_init = (state == S_INIT);
   wire can_cmd = sta1_done & !in_init & (state != S_WAKE || cnt >= WUP1_CYC);
   // combinational, so the host sees the gate in the cycle it offers a byte
   assign o_cmd_ready = can_cmd;
   wire cmd_take = cmd_valid & can_cmd;
   wire [7:0] wr_addr = i_cmd_byte - `SCMS_WRITE_OFS;
   wire is_wr = i_cmd_byte >= `SCMS_WRITE_OFS && i_cmd_byte < `SCMS_WRITE_END;
   wire is_rd = i_cmd_byte < `SCMS_WRITE_OFS;
   wire is_meas = i_cmd_byte == `SCMS_CMD_MEAS || i_cmd_byte == `SCMS_CMD_CYC;
   // polarity bit set means the select line is high active
   wire ss_act = ss_sync[1] ~^ ifcfg[`SCMS_SSPOL_BIT];

   // ****************************************
   // threshold compare
   // ****************************************
   // left aligned thresholds: thr1 is the top, thr2 the bottom 24 bits of words 13..15
   wire [47:0] th_all = {th0, th1, th2};
   wire [23:0] thr1 = th_all[47:24];
   wire [23:0] thr2 = th_all[23:0];
   wire [2:0] res_sel = cfga[`SCMS_RES_MSB:`SCMS_RES_LSB];

   // pause in clock cycles; the field encodes one to eight units
   function [31:0] scms_pause_len;
      input [2:0] f;
      begin
         scms_pause_len = CYC_UNIT * ({29'h0, f} + 32'h1);
      end
   endfunction
   wire [2:0] cyc_field = ifcfg[`SCMS_CYC_MSB:`SCMS_CYC_LSB];
   wire [31:0] pause_len = scms_pause_len(cyc_field);

   // keeps only the top (res+12) bits for comparison
   function [23:0] scms_mask;
      input [23:0] v;
      input [2:0] r;
      begin
         scms_mask = v & ~(24'hFFFFFF >> ({2'h0, r} + `SCMS_RES_BASE));
      end
   endfunction
   wire [23:0] cres = scms_mask(i_corr_result, res_sel);
   wire above = cres > scms_mask(thr1, res_sel);
   wire below = cres < scms_mask(thr2, res_sel);

   // ****************************************
   // interrupt level
   // ****************************************
   // the pin level that a finished, corrected result would show
   reg irq_lvl;
   always @* begin
      case (ifcfg[`SCMS_INT_MSB:`SCMS_INT_LSB])
         `SCMS_INT_EOC: irq_lvl = 1'b1;
         `SCMS_INT_ABOVE: irq_lvl = above;
         `SCMS_INT_BELOW: irq_lvl = below;
         default: irq_lvl = above | below;
      endcase
   end

   // ****************************************
   // interface detection
   // ****************************************
   // a reset-pin restart keeps the lock; only power-on clears it
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_if_type <= `SCMS_IF_NONE;
      end else if (o_if_type == `SCMS_IF_NONE && !in_init && !pin_fall) begin
         if (i_twi_cmd_valid && !ss_act) begin
            o_if_type <= `SCMS_IF_TWI;
         end else if (ss_act) begin
            o_if_type <= `SCMS_IF_SPI;
         end
      end
   end

   // ****************************************
   // configuration words
   // ****************************************
   // a reset-pin restart keeps the words; only power-on clears them
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ifcfg <= `SCMS_RST_WORD;
         cfga <= `SCMS_RST_WORD;
         th0 <= `SCMS_RST_WORD;
         th1 <= `SCMS_RST_WORD;
         th2 <= `SCMS_RST_WORD;
         cfgb <= `SCMS_RST_WORD;
      end else if (cmd_take && is_wr && !pin_fall) begin
         case (wr_addr)
            `SCMS_ADDR_IFCFG: ifcfg <= i_cmd_data;
            `SCMS_ADDR_CFGA: cfga <= i_cmd_data;
            `SCMS_ADDR_TH0: th0 <= i_cmd_data;
            `SCMS_ADDR_TH1: th1 <= i_cmd_data;
            `SCMS_ADDR_TH2: th2 <= i_cmd_data;
            `SCMS_ADDR_CFGB: cfgb <= i_cmd_data;
            default: ;
         endcase
      end
   end

   // ****************************************
   // read answers
   // ****************************************
   // unmapped addresses answer zero so the host never waits on them
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_read_data <= 16'h0000;
         o_read_valid <= 1'b0;
      end else if (pin_fall) begin
         o_read_valid <= 1'b0;
      end else begin
         o_read_valid <= cmd_take & is_rd;
         if (cmd_take && is_rd) begin
            case (i_cmd_byte)
               `SCMS_ADDR_IFCFG: o_read_data <= ifcfg;
               `SCMS_ADDR_CFGA: o_read_data <= cfga;
               `SCMS_ADDR_TH0: o_read_data <= th0;
               `SCMS_ADDR_TH1: o_read_data <= th1;
               `SCMS_ADDR_TH2: o_read_data <= th2;
               `SCMS_ADDR_CFGB: o_read_data <= cfgb;
               default: o_read_data <= 16'h0000;
            endcase
         end
      end
   end

   // ****************************************
   // main sequencer
   // ****************************************
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= S_INIT;
         cnt <= 32'h0;
         up_cnt <= 32'h0;
         first_cmd <= 1'b1;
         step <= 2'h0;
         cyclic <= 1'b0;
         meas_req <= 1'b0;
         o_core_on <= 1'b1;
         o_cfg_temp <= 1'b0;
         o_amp_mux <= `SCMS_MUX_ANALOG_GROUND_REF;
         o_adc_start <= 1'b0;
         o_calc_start <= 1'b0;
         o_cmd_mode <= 1'b0;
         o_conv_done <= 1'b0;
      end else if (pin_fall) begin
         // soft restart keeps the interface lock until a real power-on
         state <= S_INIT;
         cnt <= 32'h0;
         up_cnt <= 32'h0;
         first_cmd <= 1'b1;
         cyclic <= 1'b0;
         meas_req <= 1'b0;
         o_core_on <= 1'b1;
         o_cmd_mode <= 1'b0;
         o_conv_done <= 1'b0;
         o_adc_start <= 1'b0;
         o_calc_start <= 1'b0;
      end else begin
         o_adc_start <= 1'b0;
         o_calc_start <= 1'b0;
         if (!sta2_done) begin
            up_cnt <= up_cnt + 32'h1;
         end
         if (cmd_take) begin
            first_cmd <= 1'b0;
            if (i_cmd_byte == `SCMS_CMD_CM && first_cmd && !o_cmd_mode) begin
               o_cmd_mode <= 1'b1;
            end else if (i_cmd_byte == `SCMS_CMD_NOM && o_cmd_mode) begin
               o_cmd_mode <= 1'b0;
            end else if (is_meas) begin
               meas_req <= 1'b1;
               cyclic <= (i_cmd_byte == `SCMS_CMD_CYC);
            end
            if (state == S_SLEEP) begin
               state <= S_WAKE;
               o_core_on <= 1'b1;
               cnt <= 32'h0;
            end
         end
         case (state)
            S_INIT: begin
               // core reads interface config, then sleeps
               cnt <= cnt + 32'h1;
               if (cnt >= INIT_CYC) begin
                  state <= S_SLEEP;
                  o_core_on <= 1'b0;
               end
            end
            S_SLEEP: ;
            S_WAKE: begin
               if (!cmd_take) begin
                  cnt <= cnt + 32'h1;
               end
               if (cnt >= WUP2_CYC) begin
                  state <= S_ACTIVE;
               end
            end
            S_ACTIVE: begin
               if (meas_req && sta2_done) begin
                  meas_req <= 1'b0;
                  step <= 2'h0;
                  state <= S_STEP;
                  cnt <= 32'h0;
                  o_adc_start <= 1'b1;
                  o_cfg_temp <= 1'b0;
                  o_amp_mux <= `SCMS_MUX_ANALOG_GROUND_REF;
                  if (!cyclic) begin
                     o_conv_done <= 1'b0;
                  end
               // command mode never sleeps; only the normal-mode byte, a reset-pin restart or a power-on reset ends it
               end else if (!meas_req && !o_cmd_mode && !cmd_take) begin
                  state <= S_SLEEP;
                  o_core_on <= 1'b0;
               end
            end
            S_STEP: begin
               cnt <= cnt + 32'h1;
               if (cnt >= STEP_CYC) begin
                  cnt <= 32'h0;
                  // each step lasts STEP_CYC+1 cycles, launch cycle included
                  if (step == `SCMS_LAST_STEP) begin
                     state <= S_CALC;
                     o_calc_start <= 1'b1;
                  end else begin
                     step <= step + 2'h1;
                     o_adc_start <= 1'b1;
                     case (step)
                        2'h0: begin
                           o_cfg_temp <= 1'b0;
                           o_amp_mux <= `SCMS_MUX_SENSOR;
                        end
                        2'h1: begin
                           o_cfg_temp <= 1'b1;
                           o_amp_mux <= `SCMS_MUX_ANALOG_GROUND_REF;
                        end
                        default: begin
                           o_cfg_temp <= 1'b1;
                           o_amp_mux <= `SCMS_MUX_TEMP;
                        end
                     endcase
                  end
               end
            end
            S_CALC: begin
               cnt <= cnt + 32'h1;
               // only the corrected result reaches the pin
               if (i_corr_valid || cnt >= CALC_CYC) begin
                  // a timed-out calculation leaves the pin alone: no fresh result
                  if (i_corr_valid) begin
                     o_conv_done <= irq_lvl;
                  end
                  cnt <= 32'h0;
                  if (cyclic) begin
                     state <= S_PAUSE;
                     o_core_on <= o_cmd_mode;
                  end else begin
                     state <= S_ACTIVE;
                  end
               end
            end
            S_PAUSE: begin
               cnt <= cnt + 32'h1;
               // core stays off during the pause unless command mode holds it
               if (cnt >= pause_len) begin
                  meas_req <= 1'b1;
                  state <= S_ACTIVE;
                  o_core_on <= 1'b1;
                  cnt <= 32'h0;
               end
            end
            default: state <= S_INIT;
         endcase
      end
   end
endmodule

// File: sim/scms_sequencer_chk.sv
`timescale 1ns/1ps
`include "scms_regs.vh"
// ****
// port checker
// ****
module scms_sequencer_chk #(
   parameter CLK_MHZ = 250,
   parameter STA1_US = 1,
   parameter STA2_US = 2,
   parameter STEP_CYC = 64
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_ext_reset_pin,
   input wire i_slave_select,
   input wire i_twi_cmd_valid,
   input wire i_spi_cmd_valid,
   input wire [7:0] i_cmd_byte,
   input wire [15:0] i_cmd_data,
   input wire i_corr_valid,
   input wire [23:0] i_corr_result,
   input wire o_cmd_ready,
   input wire [15:0] o_read_data,
   input wire o_read_valid,
   input wire [1:0] o_if_type,
   input wire o_core_on,
   input wire o_cfg_temp,
   input wire [1:0] o_amp_mux,
   input wire o_adc_start,
   input wire o_calc_start,
   input wire o_cmd_mode,
   input wire o_conv_done
);
   localparam int ST = STEP_CYC + 1;
   wire take = (i_twi_cmd_valid | i_spi_cmd_valid) & o_cmd_ready;
   wire take_rd = take & (i_cmd_byte < 8'h40);
   // saturates so a long run cannot wrap back under the start-up limits
   reg [31:0] since_por;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) since_por <= 32'h0;
      else if (since_por < 32'hFFFF) since_por <= since_por + 32'h1;
   end
   cmd_gate_a: assert property (o_cmd_ready |-> since_por >= STA1_US * CLK_MHZ)
      else $error("command accepted too early");
   first_meas_a: assert property (o_adc_start |-> since_por >= STA2_US * CLK_MHZ)
      else $error("conversion started too early");
   meas_order_a: assert property (o_adc_start && o_amp_mux == `SCMS_MUX_ANALOG_GROUND_REF && !o_cfg_temp
      |-> ##ST (o_adc_start && o_amp_mux == `SCMS_MUX_SENSOR && !o_cfg_temp)
      ##ST (o_adc_start && o_amp_mux == `SCMS_MUX_ANALOG_GROUND_REF && o_cfg_temp)
      ##ST (o_adc_start && o_amp_mux == `SCMS_MUX_TEMP && o_cfg_temp) ##ST o_calc_start)
      else $error("measurement step order wrong");
   mux_cfg_a: assert property (o_adc_start |-> o_amp_mux == `SCMS_MUX_ANALOG_GROUND_REF
      || (o_amp_mux == `SCMS_MUX_SENSOR && !o_cfg_temp)
      || (o_amp_mux == `SCMS_MUX_TEMP && o_cfg_temp)) else $error("input routing wrong");
   rd_answer_a: assert property (take_rd |=> o_read_valid) else $error("read not answered");
   rd_cause_a: assert property (o_read_valid |-> $past(take_rd)) else $error("stray read answer");
   eoc_cause_a: assert property ($rose(o_conv_done) |-> $past(i_corr_valid))
      else $error("done rose without corrected result");
   cm_entry_a: assert property ($rose(o_cmd_mode) |-> $past(take)
      && $past(i_cmd_byte) == `SCMS_CMD_CM) else $error("command mode without entry byte");
   meas_core_a: assert property (o_adc_start |-> o_core_on)
      else $error("conversion with core off");
   if_lock_a: assert property (o_if_type != `SCMS_IF_NONE |=> $stable(o_if_type))
      else $error("interface type changed");
endmodule
bind scms_sequencer scms_sequencer_chk #(.CLK_MHZ(CLK_MHZ), .STA1_US(STA1_US),
   .STA2_US(STA2_US), .STEP_CYC(STEP_CYC)) scms_sequencer_chk_inst (.*);

// File: sim/scms_host.sv
`timescale 1ns/1ps
// ****
// host controller model
// ****
module scms_host (
   input wire i_clk_sys,
   input wire i_cmd_ready,
   input wire i_read_valid,
   input wire [15:0] i_read_data,
   output reg o_slave_select,
   output reg o_twi_valid,
   output reg o_spi_valid,
   output reg [7:0] o_cmd_byte,
   output reg [15:0] o_cmd_data
);
   reg [15:0] rdata;
   integer n;
   initial begin
      o_slave_select = 1'b1;
      o_twi_valid = 1'b0;
      o_spi_valid = 1'b0;
      o_cmd_byte = 8'h00;
      o_cmd_data = 16'h0000;
      rdata = 16'h0000;
   end
   task send(input spi, input [7:0] b, input [15:0] d);
      begin
         @(negedge i_clk_sys);
         for (n = 0; n < 5000 && !i_cmd_ready; n = n + 1) @(negedge i_clk_sys);
         o_twi_valid = !spi;
         o_spi_valid = spi;
         o_cmd_byte = b;
         o_cmd_data = d;
         @(negedge i_clk_sys);
         o_twi_valid = 1'b0;
         o_spi_valid = 1'b0;
         // released lines must not keep looking like the last command
         o_cmd_byte = ~b;
         o_cmd_data = ~d;
         if (i_read_valid) rdata = i_read_data;
      end
   endtask
endmodule

// File: sim/test_scms_sequencer.sv
`timescale 1ns/1ps
`include "scms_regs.vh"
module test_scms_sequencer;
   reg i_clk_sys = 1'b0;
   reg i_resetn = 1'b0;
   reg i_ext_reset_pin = 1'b1;
   reg i_corr_valid = 1'b0;
   reg [23:0] i_corr_result = 24'h000000;
   reg [23:0] res = 24'h000000;
   wire i_slave_select, i_twi_cmd_valid, i_spi_cmd_valid, o_cmd_ready, o_read_valid;
   wire o_core_on, o_cfg_temp, o_adc_start, o_calc_start, o_cmd_mode, o_conv_done;
   wire [7:0] i_cmd_byte;
   wire [15:0] i_cmd_data, o_read_data;
   wire [1:0] o_if_type, o_amp_mux;
   integer miscompares = 0;
   integer n_compared = 0;
   integer k;
   scms_sequencer #(.CLK_MHZ(4), .INIT_CYC(16), .CYC_UNIT(16)) scms_sequencer_inst (.*);
   scms_host scms_host_inst (.i_clk_sys(i_clk_sys), .i_cmd_ready(o_cmd_ready),
      .i_read_valid(o_read_valid), .i_read_data(o_read_data),
      .o_slave_select(i_slave_select), .o_twi_valid(i_twi_cmd_valid),
      .o_spi_valid(i_spi_cmd_valid), .o_cmd_byte(i_cmd_byte), .o_cmd_data(i_cmd_data));
   initial forever #2 i_clk_sys = ~i_clk_sys;
   // ****
   // math unit stand-in: answers one cycle after the calculation starts
   // ****
   always @(negedge i_clk_sys) begin
      i_corr_valid <= o_calc_start;
      i_corr_result <= res;
   end
   task chk(input [23:0] g, input [23:0] x);
      begin
         n_compared = n_compared + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("ERROR at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task summarize;
      begin
         if (miscompares == 0 && n_compared > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task por;
      begin
         i_resetn = 1'b0;
         repeat (3) @(negedge i_clk_sys);
         i_resetn = 1'b1;
      end
   endtask
   task wait_ready;
      for (k = 0; k < 3000 && !o_cmd_ready; k = k + 1) @(negedge i_clk_sys);
   endtask
   task wait_calc;
      begin
         for (k = 0; k < 3000 && !o_calc_start; k = k + 1) @(negedge i_clk_sys);
         @(negedge i_clk_sys);
      end
   endtask
   task meas(input [1:0] s, input [23:0] r, input e);
      begin
         scms_host_inst.send(0, 8'h42, {7'h00, s, 7'h00});
         res = r;
         scms_host_inst.send(0, `SCMS_CMD_MEAS, 16'h0000);
         for (k = 0; k < 3000 && !o_adc_start; k = k + 1) @(negedge i_clk_sys);
         chk(o_conv_done, 0);
         wait_calc;
         chk(o_conv_done, e);
      end
   endtask
   initial begin
      @(negedge i_clk_sys);
      chk({o_core_on, o_cmd_ready}, 2'h2);
      por;
      scms_host_inst.o_slave_select = 1'b0;
      @(negedge i_clk_sys);
      scms_host_inst.o_slave_select = 1'b1;
      wait_ready;
      chk({o_if_type, o_core_on}, 3'h0);
      scms_host_inst.o_slave_select = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      chk(o_if_type, `SCMS_IF_SPI);
      scms_host_inst.o_slave_select = 1'b1;
      por;
      scms_host_inst.send(0, `SCMS_CMD_CM, 16'h0000);
      chk({o_cmd_mode, o_if_type}, 3'h5);
      scms_host_inst.send(0, 8'h52, 16'h0000);
      scms_host_inst.send(0, 8'h53, 16'h8000);
      scms_host_inst.send(0, 8'h54, 16'h0F20);
      scms_host_inst.send(0, 8'h55, 16'h0000);
      scms_host_inst.send(0, `SCMS_ADDR_TH1, 16'h0000);
      chk(scms_host_inst.rdata, 16'h0F20);
      scms_host_inst.send(0, 8'h05, 16'h0000);
      chk(scms_host_inst.rdata, 16'h0000);
      meas(2'h0, 24'h123456, 1);
      meas(2'h1, 24'h900000, 1);
      meas(2'h1, 24'h800FF0, 0);
      meas(2'h2, 24'h100000, 1);
      meas(2'h2, 24'h900000, 0);
      meas(2'h3, 24'h100000, 1);
      meas(2'h3, 24'h500000, 0);
      scms_host_inst.send(0, `SCMS_CMD_NOM, 16'h0000);
      chk(o_cmd_mode, 0);
      scms_host_inst.send(0, `SCMS_CMD_CM, 16'h0000);
      chk(o_cmd_mode, 0);
      meas(2'h0, 24'h000001, 1);
      for (k = 0; k < 300 && o_core_on; k = k + 1) @(negedge i_clk_sys);
      chk(o_core_on, 0);
      i_ext_reset_pin = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      i_ext_reset_pin = 1'b1;
      chk({o_cmd_ready, o_core_on}, 2'h1);
      wait_ready;
      chk({o_cmd_ready, o_if_type}, 3'h5);
      scms_host_inst.send(0, 8'h42, 16'h0080);
      res = 24'h900000;
      scms_host_inst.send(0, `SCMS_CMD_CYC, 16'h0000);
      wait_calc;
      res = 24'h100000;
      chk(o_conv_done, 1);
      wait_calc;
      chk(o_conv_done, 0);
      summarize;
   end
   initial begin
      #200000;
      miscompares = miscompares + 1;
      summarize;
   end
endmodule
